// ---- scc_top.sv ----
// Standby control register, power state sequencing and bus-master clock gating.
`timescale 1ns/1ns
module scc_top
    import scc_pkg::*;
#(
    parameter int WAIT_BASE_STATES = 8192   // Shortest settling wait in states.
)
(
    input wire logic hclk,                    // System clock, 250 MHz.
    input wire logic hresetn,                 // Asynchronous reset, active low.
    input wire logic hsel,                    // Slave select.
    input wire logic [31:0] haddr,            // Byte address.
    input wire logic [1:0] htrans,            // Transfer type.
    input wire logic hwrite,                  // Write when high.
    input wire logic [2:0] hsize,             // Transfer size, word only.
    input wire logic [31:0] hwdata,           // Write data.
    input wire logic hready,                  // Bus ready.
    output logic hreadyout,                   // Slave ready, always high.
    output logic hresp,                       // Response, always OKAY.
    output logic [31:0] hrdata,               // Read data.
    input wire logic sleep_exec,              // One-cycle pulse per sleep instruction.
    input wire logic wake_irq,                // One-cycle wake-up interrupt pulse.
    input wire logic dtc_req,                 // Transfer controller request level.
    output logic cpu_clk_en,                  // CPU bus-master clock enable.
    output logic dtc_clk_en,                  // Transfer controller clock enable.
    output logic sleep_mode,                  // High while in sleep mode.
    output logic osc_stop,                    // High while the oscillator is stopped or settling.
    output logic clk_release                  // One-cycle pulse when clocks are released.
);
    import scc_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [7:0] sbc;                      // Standby control register.
        logic flash_en;                       // Flash register enable, gates access.
        scc_pwr_t pwr;                        // Power state.
        logic [WAIT_W-1:0] wait_cnt;          // Settling counter.
        logic [WAIT_W-1:0] wait_tgt;          // Settling length latched at wake-up.
        logic dp_wr;                          // Write data phase pending.
        logic [ADDR_W-1:0] dp_addr;           // Address of that write.
        logic [31:0] hrdata;                  // Registered read data.
        logic hreadyout;                      // Registered ready.
        logic cpu_en;                         // Registered CPU clock enable.
        logic dtc_en;                         // Registered transfer clock enable.
        logic sleep;                          // Registered sleep indicator.
        logic osc_stop;                       // Registered oscillator stop.
        logic rel;                            // Registered release pulse.
    } scc_state_t;

    scc_state_t st_r;                         // Current state.
    scc_state_t st_nxt;                       // Next state.
    logic div_tick;                           // Divided clock tick.
    logic addr_ok;                            // Valid address phase accepted.
    logic wr_sbc;                             // Accepted write to standby control.
    logic [2:0] clk_sel;                      // Current clock select code.

    // Settling length in states for a wait code; reserved codes take the longest.
    function automatic logic [WAIT_W-1:0] wait_states(input logic [2:0] code);
        logic [2:0] c;
        c = (code > WAIT_SEL_MAX) ? WAIT_SEL_MAX : code;
        return WAIT_W'(WAIT_BASE_STATES) << c;
    endfunction : wait_states

    // ****************************************************************
    // Medium-speed divider.
    // ****************************************************************
    // The divider follows the clock select field directly.
    scc_divider #(
        .DW(DIV_W)
    ) u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(clk_sel),
        .tick(div_tick)
    );

    assign clk_sel = st_r.sbc[CLK_SEL_HI:CLK_SEL_LO];
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_sbc = st_r.dp_wr && (st_r.dp_addr == OFF_STANDBY_CONTROL) && !st_r.flash_en;

    // ****************************************************************
    // Next state.
    // ****************************************************************
    // Bus slave, register writes, power sequencing and clock enables.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.hreadyout = 1'b1;
        st_nxt.rel = 1'b0;

        // Data phase of a write: only the standby control register is gated.
        if (st_r.dp_wr)
        begin
            if (wr_sbc)
            begin
                st_nxt.sbc = hwdata[7:0];
            end
            else if (st_r.dp_addr == OFF_SERIAL_TIMER)
            begin
                st_nxt.flash_en = hwdata[FLASH_EN_BIT];
            end
        end

        // Address phase: note a write, or load read data from updated values.
        st_nxt.dp_wr = addr_ok && hwrite;
        st_nxt.dp_addr = haddr[ADDR_W-1:0];
        st_nxt.hrdata = 32'h0;
        if (addr_ok && !hwrite)
        begin
            case (haddr[ADDR_W-1:0])
                OFF_STANDBY_CONTROL:
                begin
                    // Reads as zero while the gate is closed.
                    st_nxt.hrdata = st_nxt.flash_en ? 32'h0 : {24'h0, st_nxt.sbc};
                end
                OFF_SERIAL_TIMER:
                begin
                    st_nxt.hrdata = 32'(st_nxt.flash_en) << FLASH_EN_BIT;
                end
                OFF_STATUS:
                begin
                    st_nxt.hrdata = {28'h0, st_r.dtc_en, st_r.osc_stop, 2'(st_r.pwr)};
                end
                default:
                begin
                    st_nxt.hrdata = 32'h0;
                end
            endcase
        end

        // Power state sequencing.
        case (st_r.pwr)
            SCC_RUN:
            begin
                if (sleep_exec)
                begin
                    // Standby select decides the mode taken.
                    st_nxt.pwr = st_r.sbc[STBY_SEL_BIT] ? SCC_STANDBY : SCC_SLEEP;
                end
            end
            SCC_SLEEP:
            begin
                // Clocks keep running, so wake-up is immediate.
                if (wake_irq)
                begin
                    st_nxt.pwr = SCC_RUN;
                    st_nxt.rel = 1'b1;
                end
            end
            SCC_STANDBY:
            begin
                // Oscillator restarts; latch the settling length now.
                if (wake_irq)
                begin
                    st_nxt.pwr = SCC_SETTLE;
                    st_nxt.wait_cnt = '0;
                    st_nxt.wait_tgt = wait_states(st_r.sbc[WAIT_SEL_HI:WAIT_SEL_LO]);
                end
            end
            SCC_SETTLE:
            begin
                // Count states; release clocks on the last one.
                if (st_r.wait_cnt == st_r.wait_tgt - WAIT_W'(1))
                begin
                    st_nxt.pwr = SCC_RUN;
                    st_nxt.rel = 1'b1;
                end
                else
                begin
                    st_nxt.wait_cnt = st_r.wait_cnt + WAIT_W'(1);
                end
            end
            default:
            begin
                st_nxt.pwr = SCC_RUN;
            end
        endcase

        // Mode indicators follow the state being entered; clock enables follow the current state.
        st_nxt.sleep = (st_nxt.pwr == SCC_SLEEP);
        st_nxt.osc_stop = (st_nxt.pwr == SCC_STANDBY) || (st_nxt.pwr == SCC_SETTLE);
        // Full clock in high-speed mode, otherwise the divided tick.
        st_nxt.cpu_en = (st_r.pwr == SCC_RUN) && ((clk_sel == CLK_SEL_HIGH_SPEED) || div_tick);
        // The transfer controller also runs in sleep and may be boosted.
        st_nxt.dtc_en = ((st_r.pwr == SCC_RUN) || (st_r.pwr == SCC_SLEEP))
            && ((clk_sel == CLK_SEL_HIGH_SPEED) || div_tick
                || (st_r.sbc[DTC_FULL_BIT] && dtc_req));
    end

    // State register; every field resets to a constant.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
            st_r.sbc <= STANDBY_CONTROL_RST;
            st_r.flash_en <= FLASH_EN_RST;
            st_r.pwr <= SCC_RUN;
            st_r.hreadyout <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, except hresp, which is tied to OKAY.
    assign hreadyout = st_r.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st_r.hrdata;
    assign cpu_clk_en = st_r.cpu_en;
    assign dtc_clk_en = st_r.dtc_en;
    assign sleep_mode = st_r.sleep;
    assign osc_stop = st_r.osc_stop;
    assign clk_release = st_r.rel;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // A write while the gate is closed leaves the register alone.
    access_gate_a: assert property (
        (st_r.dp_wr && st_r.dp_addr == OFF_STANDBY_CONTROL && st_r.flash_en) |=> $stable(st_r.sbc))
        else $error("Standby control changed while access was gated.");

    // Sleep instruction with standby select clear enters sleep.
    sleep_entry_a: assert property (
        (st_r.pwr == SCC_RUN && sleep_exec && !st_r.sbc[STBY_SEL_BIT]) |=> sleep_mode && !osc_stop)
        else $error("Sleep mode not entered.");

    // Sleep instruction with standby select set stops the oscillator.
    standby_entry_a: assert property (
        (st_r.pwr == SCC_RUN && sleep_exec && st_r.sbc[STBY_SEL_BIT]) |=> osc_stop && !sleep_mode)
        else $error("Software standby not entered.");

    // Only an accepted software write can move standby select.
    select_hold_a: assert property (
        !wr_sbc |=> $stable(st_r.sbc[STBY_SEL_BIT]))
        else $error("Standby select changed without a write.");

    // The settling length follows the wait code at wake-up.
    wait_load_a: assert property (
        (st_r.pwr == SCC_STANDBY && wake_irq)
        |=> st_r.wait_tgt == wait_states($past(st_r.sbc[WAIT_SEL_HI:WAIT_SEL_LO])))
        else $error("Settling length does not match the wait code.");

    // Clocks come back only after the whole count.
    settle_done_a: assert property (
        $fell(osc_stop) |-> clk_release && $past(st_r.wait_cnt) == st_r.wait_tgt - WAIT_W'(1))
        else $error("Clocks released before the settling count ended.");

    // In run, a transfer request with the full-speed bit gets the full clock.
    dtc_boost_a: assert property (
        (st_r.pwr == SCC_RUN && st_r.sbc[DTC_FULL_BIT] && dtc_req) |=> dtc_clk_en)
        else $error("Transfer controller not boosted.");

    // Without the boost, medium speed gates the transfer controller too.
    medium_gate_a: assert property (
        (st_r.pwr == SCC_RUN && clk_sel != CLK_SEL_HIGH_SPEED && !div_tick
         && !(st_r.sbc[DTC_FULL_BIT] && dtc_req)) |=> !dtc_clk_en && !cpu_clk_en)
        else $error("Bus master ran off the divided tick.");

    // High-speed mode gives the CPU every cycle.
    high_speed_a: assert property (
        (st_r.pwr == SCC_RUN && clk_sel == CLK_SEL_HIGH_SPEED) |=> cpu_clk_en)
        else $error("CPU clock gated in high-speed mode.");

    // All fields read zero straight after reset.
    reset_clear_a: assert property (@(posedge hclk) disable iff (1'b0)
        !$past(hresetn) |-> st_r.sbc == STANDBY_CONTROL_RST)
        else $error("Standby control not zero after reset.");

    sleep_cov: cover property (sleep_exec && st_r.pwr == SCC_RUN ##1 sleep_mode);
    settle_cov: cover property ($fell(osc_stop));
    boost_cov: cover property (dtc_req && st_r.sbc[DTC_FULL_BIT] && clk_sel != CLK_SEL_HIGH_SPEED);
    gated_cov: cover property (st_r.dp_wr && st_r.flash_en);

endmodule : scc_top

// ---- scc_pkg.sv ----
// Shared constants and types of the standby clock control block.
package scc_pkg;

    // ****************************************************************
    // Register map, byte addresses on the AHB-Lite slave.
    // ****************************************************************
    localparam int ADDR_W = 4;                                  // Decoded low address bits.
    localparam logic [ADDR_W-1:0] OFF_STANDBY_CONTROL = 4'h0;   // Standby control register.
    localparam logic [ADDR_W-1:0] OFF_SERIAL_TIMER = 4'h4;      // Holds the access gate bit.
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;            // Read-only block state.

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int STBY_SEL_BIT = 7;                 // Standby select bit.
    localparam int WAIT_SEL_HI = 6;                  // Wait select field, top bit.
    localparam int WAIT_SEL_LO = 4;                  // Wait select field, bottom bit.
    localparam int DTC_FULL_BIT = 3;                 // Transfer controller full-speed bit.
    localparam int CLK_SEL_HI = 2;                   // Bus-master clock select, top bit.
    localparam int CLK_SEL_LO = 0;                   // Bus-master clock select, bottom bit.
    localparam int FLASH_EN_BIT = 3;                 // Flash register enable bit.
    localparam logic [7:0] STANDBY_CONTROL_RST = 8'h00; // All fields zero after reset.
    localparam logic FLASH_EN_RST = 1'b0;            // Gate open after reset.

    // ****************************************************************
    // Clock select codes and the wait counter geometry.
    // ****************************************************************
    localparam logic [2:0] CLK_SEL_HIGH_SPEED = 3'h0; // Full system clock.
    localparam logic [2:0] CLK_SEL_MAX = 3'h5;        // Slowest legal division, by 32.
    localparam logic [2:0] WAIT_SEL_MAX = 3'h5;       // Longest legal settling code.
    localparam int WAIT_W = 19;                       // Holds up to 262144 states.
    localparam int DIV_W = 5;                         // Prescaler width, divide by 32.

    // Power state of the device as seen by this block.
    typedef enum logic [1:0] {
        SCC_RUN,
        SCC_SLEEP,
        SCC_STANDBY,
        SCC_SETTLE
    } scc_pwr_t;

endpackage : scc_pkg

// ---- scc_divider.sv ----
// Medium-speed clock divider producing one-cycle enable ticks.
`timescale 1ns/1ns
module scc_divider
    import scc_pkg::*;
#(
    parameter int DW = DIV_W
)
(
    input wire logic hclk,            // System clock.
    input wire logic hresetn,         // Asynchronous reset, active low.
    input wire logic [2:0] sel,       // Division code, 0 gives every cycle.
    output logic tick                 // Registered enable at the chosen rate.
);
    import scc_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [DW-1:0] cnt;           // Free running prescaler.
        logic tick;                   // Registered tick.
    } scc_div_state_t;

    scc_div_state_t st_r;             // Current state.
    scc_div_state_t st_nxt;           // Next state.
    logic [DW-1:0] mask;              // Low counter bits that must all be one.

    // Next state: tick when the low sel bits of the counter are all ones.
    always_comb
    begin
        st_nxt = st_r;
        mask = DW'((32'h1 << sel) - 32'h1);
        st_nxt.cnt = st_r.cnt + DW'(1);
        st_nxt.tick = ((st_r.cnt & mask) == mask);
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    // A divided tick is never followed on the next cycle by another one.
    div_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel != 3'h0 && $stable(sel) && $past(sel) == sel && tick) |=> !tick)
        else $error("Divided tick came on two adjacent cycles.");

endmodule : scc_divider

// ---- test_standby_clock_control.sv ----
// Self-checking testbench of the standby clock control block.
`timescale 1ns/1ns
module test_standby_clock_control;
    import scc_pkg::*;

    // ****************************************************************
    // Signals, constants and counters.
    // ****************************************************************
    localparam int WB = 8;                                   // Short settling base for simulation.
    localparam logic [31:0] A_SBC = 32'(OFF_STANDBY_CONTROL); // Standby control address.
    localparam logic [31:0] A_STC = 32'(OFF_SERIAL_TIMER);   // Gate register address.
    localparam logic [31:0] A_STS = 32'(OFF_STATUS);         // Status address.
    localparam logic [31:0] A_BAD = 32'h0000000C;            // Unmapped address.
    logic hclk = 1'b0;                // System clock.
    logic hresetn = 1'b0;             // Reset, active low.
    logic hsel = 1'b0;                // Slave select.
    logic [31:0] haddr = 32'h0;       // Address.
    logic [1:0] htrans = 2'h0;        // Transfer type.
    logic hwrite = 1'b0;              // Write flag.
    logic [2:0] hsize = 3'h2;         // Word size.
    logic [31:0] hwdata = 32'h0;      // Write data.
    logic hreadyout;                  // Slave ready.
    logic hresp;                      // Response.
    logic [31:0] hrdata;              // Read data.
    logic sleep_exec = 1'b0;          // Sleep instruction pulse.
    logic wake_irq = 1'b0;            // Wake interrupt pulse.
    logic dtc_req = 1'b0;             // Transfer controller request.
    logic cpu_clk_en, dtc_clk_en, sleep_mode, osc_stop, clk_release;
    int fail_count = 0;               // Mismatches seen.
    int tests_run = 0;                // Comparisons made.
    int seed = 32'h3764;              // Fixed random seed.

    scc_top #(.WAIT_BASE_STATES(WB)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
        .dtc_req(dtc_req), .cpu_clk_en(cpu_clk_en), .dtc_clk_en(dtc_clk_en), .sleep_mode(sleep_mode),
        .osc_stop(osc_stop), .clk_release(clk_release));

    // The clock toggles every half period of 2 ns.
    initial
    begin
        forever #2 hclk = ~hclk;
    end

    // ****************************************************************
    // Expectations, comparison and bus tasks.
    // ****************************************************************
    // Enable pulses seen in a window, one in 2^code cycles.
    function automatic int exp_count(input int code, input int cycles);
        return cycles >> code;
    endfunction : exp_count

    // Settling length in states, reserved codes act as the longest.
    function automatic int exp_wait(input int code);
        return WB << ((code > 5) ? 5 : code);
    endfunction : exp_wait

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Waits for ready at a rising edge, capturing read data just before it.
    task automatic wait_ready(output logic [31:0] rd);
        logic rdy;
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            rdy = hreadyout;
            rd = hrdata;
            @(posedge hclk);
            n++;
        end while (rdy !== 1'b1 && n < 100);
        if (rdy !== 1'b1)
        begin
            fail_count++;
            $display("BAD %0t bus never ready", $time);
        end
    endtask : wait_ready

    // One single AHB-Lite transfer: address phase, then data phase.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
        check({31'h0, hresp}, 32'h0, "response not OKAY");
    endtask : ahb

    // Register write.
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : reg_wr

    // Register read and compare.
    task automatic reg_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(x, e, "register read");
    endtask : reg_chk

    // Counts both clock enables over a window after letting them settle.
    task automatic count_en(input int cycles, output int nc, output int nd);
        nc = 0;
        nd = 0;
        repeat (8) @(posedge hclk);
        repeat (cycles)
        begin
            @(posedge hclk);
            #1;
            nc += (cpu_clk_en === 1'b1);
            nd += (dtc_clk_en === 1'b1);
        end
    endtask : count_en

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // A hang is cut short well beyond the expected run length.
    initial
    begin
        #200000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        logic [7:0] v;
        logic [7:0] keep;
        int nc, nd, cnt, gap;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reg_chk(A_SBC, 32'h0);
        reg_chk(A_STC, 32'h0);
        // Run state after reset, with the transfer controller clock already on.
        reg_chk(A_STS, 32'h8);
        // Random fields read back; prohibited clock codes are never written.
        for (int i = 0; i < 8; i++)
        begin
            v = {1'($random(seed)), 3'(($random(seed) & 32'h7FFF) % 6), 1'($random(seed)),
                3'(($random(seed) & 32'h7FFF) % 6)};
            reg_wr(A_SBC, {24'h0, v});
            reg_wr(A_BAD, $random(seed));
            reg_chk(A_SBC, {24'h0, v});
            reg_chk(A_BAD, 32'h0);
        end
        // Gate set: writes dropped and reads zero; gate cleared: old value back.
        keep = v;
        reg_wr(A_STC, 32'h8);
        reg_chk(A_STC, 32'h8);
        reg_wr(A_SBC, {24'h0, ~keep});
        reg_chk(A_SBC, 32'h0);
        reg_wr(A_STC, 32'h0);
        reg_chk(A_SBC, {24'h0, keep});
        // Every legal clock code, 0 to 5, with and without a forced full-speed transfer request.
        for (int code = 0; code < 6; code++)
        begin
            reg_wr(A_SBC, {24'h0, 4'h0, 1'b0, 3'(code)});
            count_en(64, nc, nd);
            check(32'(nc), 32'(exp_count(code, 64)), "cpu enable rate");
            check(32'(nd), 32'(exp_count(code, 64)), "dtc enable rate");
            reg_wr(A_SBC, {24'h0, 4'h0, 1'b1, 3'(code)});
            dtc_req <= 1'b1;
            count_en(64, nc, nd);
            check(32'(nc), 32'(exp_count(code, 64)), "cpu rate with request");
            check(32'(nd), 32'd64, "dtc full speed on request");
            dtc_req <= 1'b0;
        end
        // A wake pulse in run changes nothing.
        wake_irq <= 1'b1;
        @(posedge hclk);
        wake_irq <= 1'b0;
        repeat (3)
        begin
            @(posedge hclk);
            #1;
            check({31'h0, clk_release}, 32'h0, "release in run");
        end
        // Sleep entry and wake with standby select clear.
        reg_wr(A_SBC, 32'h0);
        sleep_exec <= 1'b1;
        @(posedge hclk);
        sleep_exec <= 1'b0;
        // Enables are registered from the held state, so they drop one edge after the mode.
        @(posedge hclk);
        #1;
        check({29'h0, sleep_mode, osc_stop, cpu_clk_en}, 32'h4, "sleep entry");
        // Sleep state, and the transfer controller keeps its full clock.
        reg_chk(A_STS, 32'h9);
        wake_irq <= 1'b1;
        @(posedge hclk);
        wake_irq <= 1'b0;
        #1;
        check({30'h0, sleep_mode, clk_release}, 32'h1, "sleep wake");
        // Standby entry and settling for every wait code, reserved ones too.
        for (int code = 0; code < 8; code++)
        begin
            // Every settling length that software may pick for a resonator or an external clock.
            v = {1'b1, 3'(code), 4'h0};
            reg_wr(A_SBC, {24'h0, v});
            sleep_exec <= 1'b1;
            @(posedge hclk);
            sleep_exec <= 1'b0;
            @(posedge hclk);
            #1;
            check({29'h0, osc_stop, cpu_clk_en, dtc_clk_en}, 32'h4, "standby entry");
            reg_chk(A_STS, 32'h6);
            gap = ($random(seed) & 32'hF) + 1;
            repeat (gap) @(posedge hclk);
            wake_irq <= 1'b1;
            // The wake edge starts the count; release comes that many edges later.
            @(posedge hclk);
            wake_irq <= 1'b0;
            cnt = 0;
            do
            begin
                @(posedge hclk);
                cnt++;
                #1;
            end while (clk_release !== 1'b1 && cnt < 400);
            check(32'(cnt), 32'(exp_wait(code)), "settling length");
            check({31'h0, osc_stop}, 32'h0, "oscillator running after settling");
            reg_chk(A_SBC, {24'h0, v});
        end
        conclude();
    end

endmodule : test_standby_clock_control
